// ==== shared/lpt_pkg.sv ====
// Package for the pixel serializer transmitter: word layout, slot timing,
// power-down and lock timing constants.
// Assumes a single 10 MHz system clock; every serial slot lasts one clock.
package lpt_pkg;

  // Four control lines: line sync, frame sync, display enable and a spare.
  typedef struct packed {
    logic       spare;
    logic       display_enable;
    logic       frame_sync;
    logic       line_sync;
  } lpt_ctrl_t;

  typedef struct packed {
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
    lpt_ctrl_t  ctrl;
  } lpt_pixel_t;

  localparam int unsigned LPT_WORD_W   = $bits(lpt_pixel_t);
  localparam int unsigned LPT_LANES    = 4;
  localparam int unsigned LPT_SLOTS    = 7;
  localparam int unsigned LPT_FIFO_DEP = 8;

  localparam logic [2:0] LPT_SLOT_FIRST = 3'h0;
  localparam logic [2:0] LPT_SLOT_LAST  = 3'h6;

  // Forwarded clock level per slot: high in slots 0, 1, 5 and 6.
  localparam logic [6:0] LPT_CLK_PATTERN = 7'h63;

  localparam int unsigned LPT_SYS_PERIOD_NS = 100;
  localparam int unsigned LPT_PD_DELAY_NS   = 100;
  localparam int unsigned LPT_PD_DELAY_RAW  = LPT_PD_DELAY_NS / LPT_SYS_PERIOD_NS;
  localparam int unsigned LPT_PD_DELAY_CYC  = (LPT_PD_DELAY_RAW < 1) ? 1 : LPT_PD_DELAY_RAW;

  localparam int unsigned LPT_LOCK_TIME_MS = 10;
  localparam int unsigned LPT_LOCK_CYCLES  = (LPT_LOCK_TIME_MS * 1000000 + LPT_SYS_PERIOD_NS - 1)
                                             / LPT_SYS_PERIOD_NS;
  localparam int unsigned LPT_LOCK_CNT_W   = 17;

  typedef struct packed {
    logic [LPT_LANES-1:0] pos;
    logic [LPT_LANES-1:0] neg;
  } lpt_lanes_t;

endpackage

// ==== testbench/lpt_rx_model.sv ====
// Panel-side receiver model: rebuilds pixel words from the four serial lanes.
// Assumes one slot per system clock and the forwarded clock pattern of the package.
`timescale 1ns/1ps
`default_nettype none
module lpt_rx_model
  import lpt_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic [LPT_LANES-1:0]  lane_i,
  input  wire logic                  lane_oe_i,
  input  wire logic                  clk_i,
  input  wire logic                  clk_oe_i,
  output logic      [LPT_WORD_W-1:0] word_o,
  output logic                       word_stb_o,
  output logic                       clk_bad_o
);
  logic [LPT_LANES-1:0]  lane_w, lane_q;
  logic                  clk_w, clk_q, aligned, started;
  logic [2:0]            slot, s;
  logic [LPT_WORD_W-1:0] acc;
  // A released pair shows the inverse of its last level, so stale bits never decode.
  assign lane_w = lane_oe_i ? lane_i : ~lane_q;
  assign clk_w  = clk_oe_i ? clk_i : ~clk_q;
  initial begin
    {lane_q, clk_q, aligned, started, slot, word_stb_o, clk_bad_o} = '0;
  end
  always @(posedge sys_clk_i) begin
    if (lane_oe_i) begin
      lane_q <= lane_i;
    end
    if (clk_oe_i) begin
      clk_q <= clk_i;
    end
    word_stb_o <= 1'b0;
    s = (clk_q && !clk_w) ? 3'h2 : ((slot == 3'h6) ? 3'h0 : slot + 3'h1);
    slot <= s;
    for (int k = 0; k < LPT_LANES; k++) acc[7*k+int'(s)] = lane_w[k];
    if (!(lane_oe_i && clk_oe_i)) begin
      aligned <= 1'b0;
      started <= 1'b0;
    end else begin
      if (clk_q && !clk_w) aligned <= 1'b1;
      if (s == 3'h0 && aligned) started <= 1'b1;
      if (aligned && clk_w !== LPT_CLK_PATTERN[s]) clk_bad_o <= 1'b1;
      if (s == 3'h6 && started && acc != '0) begin
        word_o <= acc;
        word_stb_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_lvds_pixel_serializer_tx.sv ====
// Self-checking bench for the pixel serializer transmitter.
// Assumes the receiver model beside it and a shortened lock interval.
`timescale 1ns/1ps
`default_nettype none
module tb_lvds_pixel_serializer_tx
  import lpt_pkg::*;
();
  localparam int LOCK_CYC = 20;
  logic                  sys_clk, arst_n, pix_clk, pd_n;
  lpt_pixel_t            pix;
  logic [LPT_LANES-1:0]  lane_p, lane_n;
  logic                  lane_oe, fclk_p, fclk_n, fclk_oe, link_valid, cap_ready, cap_drop;
  logic [LPT_WORD_W-1:0] rx_word;
  logic                  rx_stb, clk_bad;
  logic [LPT_WORD_W-1:0] exp_q[$];
  logic [31:0]           lfsr;
  int                    bad_count, checks_done, drops;

  lpt_serializer_tx #(.LOCK_CYCLES(LOCK_CYC)) dut (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .pixel_shift_clock_in_i(pix_clk),
    .pixel_parallel_inputs_i(pix), .power_down_n_i(pd_n),
    .serial_lane_outputs_p_o(lane_p), .serial_lane_outputs_n_o(lane_n), .serial_lane_oe_o(lane_oe),
    .forwarded_link_clock_p_o(fclk_p), .forwarded_link_clock_n_o(fclk_n),
    .forwarded_link_clock_oe_o(fclk_oe), .link_valid_o(link_valid),
    .capture_ready_o(cap_ready), .capture_drop_o(cap_drop));

  lpt_rx_model rx (
    .sys_clk_i(sys_clk), .lane_i(lane_p), .lane_oe_i(lane_oe), .clk_i(fclk_p),
    .clk_oe_i(fclk_oe), .word_o(rx_word), .word_stb_o(rx_stb), .clk_bad_o(clk_bad));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check_word(string what, logic [LPT_WORD_W-1:0] e, logic [LPT_WORD_W-1:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_bit(string what, logic e, logic g);
    check_word(what, {27'h0, e}, {27'h0, g});
  endtask

  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Low phase of at least one cycle so a drop pulse is seen before the next strobe.
  task automatic send_word(int lo, int hi);
    lfsr = lfsr_next(lfsr);
    pix = lpt_pixel_t'(lfsr[27:0] | 28'h1);
    pix_clk = 1'b0;
    exp_q.push_back(pix);
    for (int i = 0; i < lo; i++) begin
      @(negedge sys_clk);
      if (cap_drop === 1'b1) begin
        void'(exp_q.pop_back());
        drops++;
      end
    end
    pix_clk = 1'b1;
    repeat (hi) @(negedge sys_clk);
  endtask

  task automatic power_up();
    int n;
    pd_n = 1'b1;
    n = 0;
    while (link_valid !== 1'b1 && n < 4 * LOCK_CYC) begin
      @(negedge sys_clk);
      n++;
    end
    check_bit("lock wait long enough", 1'b1, n >= LOCK_CYC);
    check_bit("link valid", 1'b1, link_valid);
    repeat (2) @(negedge sys_clk);
    check_bit("lane enable", 1'b1, lane_oe);
    check_bit("capture ready", 1'b1, cap_ready);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check_bit("queue drained", 1'b1, exp_q.size() == 0);
  endtask

  always @(negedge sys_clk) begin
    if (rx_stb === 1'b1) begin
      if (exp_q.size() == 0) check_word("unexpected word", '0, rx_word);
      else check_word("lane word", exp_q.pop_front(), rx_word);
    end
    if (lane_oe === 1'b1) check_word("complement pairs", {23'h0, ~lane_p, ~fclk_p}, {23'h0, lane_n, fclk_n});
  end

  initial begin
    arst_n = 1'b0;
    pd_n = 1'b0;
    pix_clk = 1'b1;
    pix = '0;
    lfsr = 32'hA7A8;
    repeat (8) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    check_bit("lane enable in power-down", 1'b0, lane_oe);
    check_bit("clock enable in power-down", 1'b0, fclk_oe);
    power_up();
    repeat (12) send_word(4, 4);
    drain();
    $display("Test stream done");
    repeat (40) send_word(2, 2);
    drain();
    check_bit("overflow drop seen", 1'b1, drops > 0);
    $display("Test burst done");
    repeat (3) send_word(4, 4);
    pd_n = 1'b0;
    @(negedge sys_clk);
    check_bit("lane enable after power-down", 1'b0, lane_oe);
    check_bit("clock enable after power-down", 1'b0, fclk_oe);
    check_bit("link valid after power-down", 1'b0, link_valid);
    @(negedge sys_clk);
    exp_q.delete();
    power_up();
    repeat (4) send_word(4, 4);
    drain();
    check_bit("forwarded clock pattern fault", 1'b0, clk_bad);
    $display("Test power-down done");
    tally_and_finish();
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    bad_count++;
    $display("ERROR watchdog expected end seen timeout");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== verilog/lpt_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lpt_fifo #(
  parameter int unsigned WIDTH = 28,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_ff != CW'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i && in_ready_o && !flush_i;
  assign pop         = out_valid_o && out_ready_i && !flush_i;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else if (flush_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= CW'(count_ff + 1'b1);
      end else if (pop && !push) begin
        count_ff <= CW'(count_ff - 1'b1);
      end
    end
  end

  fifo_no_overflow_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    count_ff <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

// ==== verilog/lpt_serializer_tx.sv ====
// Pixel serializer transmitter: samples 28 parallel inputs on the falling
// pixel clock edge, buffers them and sends them over four serial lanes plus a
// forwarded clock lane, seven slots per word.
// Assumes all inputs are synchronous to sys_clk_i and the pixel clock is at
// least seven system clocks long; serial pins go to high impedance via enables.
//
// Behaviour
// - Sample inputs on each falling pixel clock edge; the code drops the word when the buffer is full.
// - Drive four complementary serial data lanes.
// - Seven ordered bit slots per word period.
// - Forward a derived clock on fifth pair.
// - Power-down low disables every serial output.
// - Outputs disabled within 100 ns of power-down.
// - Data valid only after lock interval elapses.
// - Bit mapping is free but must match receiver.
`timescale 1ns/1ps
`default_nettype none
module lpt_serializer_tx
  import lpt_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LPT_LOCK_CYCLES
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 pixel_shift_clock_in_i,
  input  wire lpt_pixel_t           pixel_parallel_inputs_i,
  input  wire logic                 power_down_n_i,
  output logic     [LPT_LANES-1:0]  serial_lane_outputs_p_o,
  output logic     [LPT_LANES-1:0]  serial_lane_outputs_n_o,
  output logic                      serial_lane_oe_o,
  output logic                      forwarded_link_clock_p_o,
  output logic                      forwarded_link_clock_n_o,
  output logic                      forwarded_link_clock_oe_o,
  output logic                      link_valid_o,
  output logic                      capture_ready_o,
  output logic                      capture_drop_o
);

  logic                      pix_clk_d_ff;
  logic                      pix_fall;
  logic [LPT_LOCK_CNT_W-1:0] lock_cnt_ff;
  logic                      locked_ff;
  logic [2:0]                slot_ff;
  lpt_pixel_t                cur_word_ff;
  lpt_lanes_t                lanes_ff;
  logic                      lane_oe_ff;
  logic                      clk_p_ff;
  logic                      clk_n_ff;
  logic                      clk_oe_ff;
  logic                      link_valid_ff;
  logic                      cap_ready_ff;
  logic                      cap_drop_ff;
  logic                      fifo_in_valid;
  logic                      fifo_in_ready;
  logic                      fifo_out_valid;
  logic                      fifo_out_ready;
  lpt_pixel_t                fifo_out_data;
  logic [LPT_WORD_W-1:0]     fifo_out_raw;
  logic                      word_end;

  // Bit of a word that a lane carries in a slot; lane k owns bits 7k..7k+6.
  function automatic logic [LPT_LANES-1:0] lane_slot_bits(input lpt_pixel_t w, input logic [2:0] s);
    logic [LPT_WORD_W-1:0] flat;
    flat = w;
    for (int k = 0; k < LPT_LANES; k++) begin
      lane_slot_bits[k] = flat[k * LPT_SLOTS + int'(s)];
    end
  endfunction

  // The pixel clock is synchronous, so one delay stage suffices for the edge.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pix_clk_d_ff <= 1'b0;
    end else begin
      pix_clk_d_ff <= pixel_shift_clock_in_i;
    end
  end

  assign pix_fall = pix_clk_d_ff && !pixel_shift_clock_in_i;

  // Words are only accepted once the lock interval has passed.
  assign fifo_in_valid = pix_fall && locked_ff && power_down_n_i;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_cnt_ff <= '0;
      locked_ff   <= 1'b0;
    end else if (!power_down_n_i) begin
      lock_cnt_ff <= '0;
      locked_ff   <= 1'b0;
    end else if (!locked_ff) begin
      if (lock_cnt_ff == LPT_LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
        locked_ff <= 1'b1;
      end else begin
        lock_cnt_ff <= LPT_LOCK_CNT_W'(lock_cnt_ff + 1'b1);
      end
    end
  end

  lpt_fifo #(
    .WIDTH (LPT_WORD_W),
    .DEPTH (LPT_FIFO_DEP)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .flush_i     (!power_down_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pixel_parallel_inputs_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_raw)
  );

  assign fifo_out_data  = lpt_pixel_t'(fifo_out_raw);
  assign word_end       = power_down_n_i && (slot_ff == LPT_SLOT_LAST);
  assign fifo_out_ready = word_end;

  // Slot counter: one slot per system clock, wrapping after slot six.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slot_ff <= LPT_SLOT_FIRST;
    end else if (!power_down_n_i || word_end) begin
      slot_ff <= LPT_SLOT_FIRST;
    end else begin
      slot_ff <= 3'(slot_ff + 1'b1);
    end
  end

  // An empty buffer sends an all-zero word, which holds display enable low.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_word_ff <= '0;
    end else if (!power_down_n_i) begin
      cur_word_ff <= '0;
    end else if (word_end) begin
      cur_word_ff <= fifo_out_valid ? fifo_out_data : '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lanes_ff   <= '0;
      lane_oe_ff <= 1'b0;
    end else if (!power_down_n_i) begin
      lanes_ff   <= '0;
      lane_oe_ff <= 1'b0;
    end else begin
      lanes_ff.pos <= lane_slot_bits(cur_word_ff, slot_ff);
      lanes_ff.neg <= ~lane_slot_bits(cur_word_ff, slot_ff);
      lane_oe_ff   <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_p_ff  <= 1'b0;
      clk_n_ff  <= 1'b0;
      clk_oe_ff <= 1'b0;
    end else if (!power_down_n_i) begin
      clk_p_ff  <= 1'b0;
      clk_n_ff  <= 1'b0;
      clk_oe_ff <= 1'b0;
    end else begin
      clk_p_ff  <= LPT_CLK_PATTERN[slot_ff];
      clk_n_ff  <= !LPT_CLK_PATTERN[slot_ff];
      clk_oe_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_valid_ff <= 1'b0;
      cap_ready_ff  <= 1'b0;
      cap_drop_ff   <= 1'b0;
    end else begin
      link_valid_ff <= locked_ff && power_down_n_i;
      cap_ready_ff  <= fifo_in_ready && locked_ff && power_down_n_i;
      cap_drop_ff   <= fifo_in_valid && !fifo_in_ready;
    end
  end

  assign serial_lane_outputs_p_o   = lanes_ff.pos;
  assign serial_lane_outputs_n_o   = lanes_ff.neg;
  assign serial_lane_oe_o          = lane_oe_ff;
  assign forwarded_link_clock_p_o  = clk_p_ff;
  assign forwarded_link_clock_n_o  = clk_n_ff;
  assign forwarded_link_clock_oe_o = clk_oe_ff;
  assign link_valid_o              = link_valid_ff;
  assign capture_ready_o           = cap_ready_ff;
  assign capture_drop_o            = cap_drop_ff;

  sequence clk_ref_high_s;
    forwarded_link_clock_p_o [*2];
  endsequence

  sequence clk_mid_low_s;
    !forwarded_link_clock_p_o [*3];
  endsequence

  capture_on_fall_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    pix_fall && locked_ff && power_down_n_i && fifo_in_ready |=> fifo_out_valid || !power_down_n_i)
    else $error("falling edge word not buffered");

  no_early_push_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !link_valid_o && !locked_ff |-> !fifo_out_valid || $past(locked_ff))
    else $error("word buffered before lock");

  lock_time_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i || !power_down_n_i)
    !locked_ff && lock_cnt_ff == LPT_LOCK_CNT_W'(LOCK_CYCLES - 1) |=> ##1 link_valid_o)
    else $error("link not valid after lock interval");

  pd_invalid_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !power_down_n_i |=> !link_valid_o && !locked_ff) else $error("link valid during power-down");

  pd_release_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !power_down_n_i |=> !serial_lane_oe_o && !forwarded_link_clock_oe_o)
    else $error("outputs enabled after power-down");

  pd_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !serial_lane_oe_o |-> serial_lane_outputs_p_o == '0 && !forwarded_link_clock_oe_o)
    else $error("lanes active while disabled");

  lane_compl_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    serial_lane_oe_o |-> serial_lane_outputs_n_o == ~serial_lane_outputs_p_o)
    else $error("lane pair not complementary");

  slot_wrap_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    power_down_n_i && slot_ff == LPT_SLOT_LAST |=> slot_ff == LPT_SLOT_FIRST)
    else $error("slot counter did not wrap after seven");

  clk_shape_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i || !power_down_n_i)
    slot_ff == LPT_SLOT_FIRST |=> clk_ref_high_s ##1 clk_mid_low_s ##1 clk_ref_high_s)
    else $error("forwarded clock shape wrong");

  word_load_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    word_end && fifo_out_valid |=> cur_word_ff == $past(fifo_out_data) || !power_down_n_i)
    else $error("next word not loaded at word end");

  slot_zero_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i || !power_down_n_i)
    slot_ff == LPT_SLOT_FIRST |=> serial_lane_outputs_p_o ==
      {$past(cur_word_ff[3 * LPT_SLOTS]), $past(cur_word_ff[2 * LPT_SLOTS]), $past(cur_word_ff[LPT_SLOTS]),
       $past(cur_word_ff[0])})
    else $error("slot zero bits wrong");
endmodule
`default_nettype wire
